// File: dimx_pkg.sv
package dimx_pkg;

	// ==========================================================
	// widths and arithmetic
	localparam int DW   = 16;
	localparam int ACCW = 40;

	typedef struct packed {
		logic signed [15:0] a;
		logic signed [15:0] b;
	} dimx_pair_type;

	localparam dimx_pair_type PAIR_RST = 32'h0000_0000;

	// ==========================================================
	// half-band interpolator: 15 nonzero side taps, outer to inner
	localparam int HB_NZ  = 15;
	localparam int HB_LEN = 30;
	localparam int HB_MID = 15;
	localparam logic signed [17:0] HB_COEF [HB_NZ] = '{
		18'sh00004, -18'sh0000C, 18'sh0001C, -18'sh0003A, 18'sh0006C,
		-18'sh000BC, 18'sh00134, -18'sh001E3, 18'sh002DE, -18'sh00443,
		18'sh00647, -18'sh00958, 18'sh00E94, -18'sh01A19, 18'sh05120};
	localparam logic signed [17:0] HB_CENTER = 18'sh08000;
	// zero stuffing doubles the sample, then divide by 65536 with rounding
	localparam int                 HB_SHIFT  = 16;
	localparam logic signed [39:0] HB_RND    = 40'sh00_0000_8000;

	// ==========================================================
	// droop correction: 1, -5, 264, -5, 1, scaled by 1/256
	localparam int DR_TAPS = 5;
	localparam logic signed [11:0] DR_COEF [DR_TAPS] = '{
		12'sh001, -12'sh005, 12'sh108, -12'sh005, 12'sh001};
	localparam int                 DR_SHIFT = 8;
	localparam logic signed [39:0] DR_RND   = 40'sh00_0000_0080;

	// ==========================================================
	// coarse mixer modes
	typedef enum logic [1:0] {
		MIX_NONE = 2'h0,
		MIX_FS2  = 2'h1,
		MIX_PFS4 = 2'h2,
		MIX_MFS4 = 2'h3
	} dimx_mix_type;

	// ==========================================================
	// offset holding registers, 8 bits each
	localparam int               OFW          = 13;
	localparam logic [1:0]       OFS_IDX_TRIG = 2'h0;
	localparam logic [1:0]       OFS_IDX_A_HI = 2'h1;
	localparam logic [1:0]       OFS_IDX_B_LO = 2'h2;
	localparam logic [1:0]       OFS_IDX_LAST = 2'h3;
	localparam logic signed [12:0] OFS_RST    = 13'h0000;
	localparam logic [7:0]       HOLD_RST     = 8'h00;

	// ==========================================================
	function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
		if (v > 40'sh00_0000_7FFF)
			return 16'sh7FFF;
		else if (v < -40'sh00_0000_8000)
			return 16'sh8000;
		else
			return v[15:0];
	endfunction

	function automatic logic signed [15:0] neg16(input logic signed [15:0] v);
		if (v == 16'sh8000)
			return 16'sh7FFF;
		else
			return -v;
	endfunction

endpackage

// File: dimx_halfband.sv
`timescale 1ns/1ps
module dimx_halfband (
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	input  wire logic               i_en,
	input  wire logic signed [15:0] i_x,
	output logic signed [15:0]      o_center,
	output logic signed [15:0]      o_interp
);

	// ==========================================================
	// polyphase form: newest sample at x_r[0]
	logic signed [15:0] x_r [dimx_pkg::HB_LEN];
	logic signed [39:0] prod [dimx_pkg::HB_NZ];
	logic signed [39:0] acc_i;
	logic signed [39:0] acc_c;

	genvar k;
	generate
		for (k = 0; k < dimx_pkg::HB_NZ; k++) begin : g_tap
			logic signed [16:0] pair;
			assign pair    = 17'(x_r[k]) + 17'(x_r[dimx_pkg::HB_LEN - 1 - k]);
			assign prod[k] = 40'(pair) * 40'(dimx_pkg::HB_COEF[k]);
		end
	endgenerate

	always_comb begin
		acc_i = '0;
		for (int n = 0; n < dimx_pkg::HB_NZ; n++) begin
			acc_i = acc_i + prod[n];
		end
		acc_c = 40'(x_r[dimx_pkg::HB_MID]) * 40'(dimx_pkg::HB_CENTER);
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			for (int n = 0; n < dimx_pkg::HB_LEN; n++) begin
				x_r[n] <= 16'sh0000;
			end
		end else if (i_en) begin
			x_r[0] <= i_x;
			for (int n = 1; n < dimx_pkg::HB_LEN; n++) begin
				x_r[n] <= x_r[n-1];
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_center <= 16'sh0000;
			o_interp <= 16'sh0000;
		end else if (i_en) begin
			o_center <= dimx_pkg::sat16(((acc_c <<< 1) + dimx_pkg::HB_RND) >>> dimx_pkg::HB_SHIFT);
			o_interp <= dimx_pkg::sat16(((acc_i <<< 1) + dimx_pkg::HB_RND) >>> dimx_pkg::HB_SHIFT);
		end
	end

endmodule

// File: dimx_path.sv
// Notes on behaviour
// - symmetric 59-tap half-band interpolator, fixed taps
// - five-tap droop filter 1,-5,264,-5,1
// - mixing only while interpolator enabled
// - A real, B imaginary complex mix
// - two-bit select: none, fs/2, +fs/4, -fs/4
// - 00 passes; 01 negates every second sample
// - quarter-rate rotation sequences, one step per output
// - fs/2 keeps channels independent
// - per-channel 13-bit signed offset
// - trigger write loads both active offsets together
// - other offset writes only touch holding storage
// - offset added LSB aligned before conversion
// - droop filter before interpolator, input rate, gated
// - interpolator yields two outputs per input
`timescale 1ns/1ps
module dimx_path (
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rst,
	input  wire dimx_pkg::dimx_pair_type i_smp,
	output dimx_pkg::dimx_pair_type     o_dac,
	output logic                        o_dac_valid,
	output logic                        o_smp_take,
	input  wire logic                   i_hb_en,
	input  wire logic                   i_droop_en,
	input  wire logic [1:0]             i_mix_sel,
	input  wire logic                   i_offset_wr,
	input  wire logic [1:0]             i_offset_idx,
	input  wire logic [7:0]             i_offset_data,
	output logic signed [12:0]          o_offset_a,
	output logic signed [12:0]          o_offset_b
);

	// ==========================================================
	// input-rate enable: every second clock
	logic in_en_r;

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			in_en_r <= 1'b0;
		else
			in_en_r <= ~in_en_r;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			o_smp_take <= 1'b0;
		else
			o_smp_take <= ~in_en_r;
	end

	// ==========================================================
	// droop correction, per channel at input rate
	logic signed [15:0] x_in [2];
	logic signed [15:0] dr_r [2];
	logic signed [15:0] hb_c [2];
	logic signed [15:0] hb_i [2];
	logic               droop_on;

	assign x_in[0]  = i_smp.a;
	assign x_in[1]  = i_smp.b;
	assign droop_on = i_droop_en & i_hb_en;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			logic signed [15:0] dl_r [dimx_pkg::DR_TAPS - 1];
			logic signed [39:0] dacc;

			always_comb begin
				dacc = 40'(x_in[ch]) * 40'(dimx_pkg::DR_COEF[0]);
				for (int n = 1; n < dimx_pkg::DR_TAPS; n++) begin
					dacc = dacc + 40'(dl_r[n-1]) * 40'(dimx_pkg::DR_COEF[n]);
				end
			end

			always_ff @(posedge i_clk_sys or posedge i_rst) begin
				if (i_rst) begin
					for (int n = 0; n < dimx_pkg::DR_TAPS - 1; n++) begin
						dl_r[n] <= 16'sh0000;
					end
					dr_r[ch] <= 16'sh0000;
				end else if (in_en_r) begin
					dl_r[0] <= x_in[ch];
					for (int n = 1; n < dimx_pkg::DR_TAPS - 1; n++) begin
						dl_r[n] <= dl_r[n-1];
					end
					if (droop_on)
						dr_r[ch] <= dimx_pkg::sat16((dacc + dimx_pkg::DR_RND) >>> dimx_pkg::DR_SHIFT);
					else
						dr_r[ch] <= x_in[ch];
				end
			end

			dimx_halfband u_hb (
				.i_clk_sys (i_clk_sys),
				.i_rst     (i_rst),
				.i_en      (in_en_r),
				.i_x       (dr_r[ch]),
				.o_center  (hb_c[ch]),
				.o_interp  (hb_i[ch])
			);
		end
	endgenerate

	// ==========================================================
	// sample selection and coarse mixer
	dimx_pkg::dimx_mix_type mode_eff;
	logic signed [15:0]     sa;
	logic signed [15:0]     sb;
	logic signed [15:0]     ma;
	logic signed [15:0]     mb;
	logic signed [15:0]     mix_a_r;
	logic signed [15:0]     mix_b_r;
	logic                   mix_vld_r;
	logic                   mix_vld_nxt;
	logic [1:0]             cnt_r;

	assign mode_eff    = i_hb_en ? dimx_pkg::dimx_mix_type'(i_mix_sel)
	                             : dimx_pkg::MIX_NONE;
	assign mix_vld_nxt = i_hb_en | ~in_en_r;

	always_comb begin
		if (!i_hb_en) begin
			sa = dr_r[0];
			sb = dr_r[1];
		end else if (in_en_r) begin
			sa = hb_i[0];
			sb = hb_i[1];
		end else begin
			sa = hb_c[0];
			sb = hb_c[1];
		end
	end

	always_comb begin
		ma = sa;
		mb = sb;
		case (mode_eff)
			dimx_pkg::MIX_NONE: begin
				ma = sa;
				mb = sb;
			end
			dimx_pkg::MIX_FS2: begin
				ma = cnt_r[0] ? dimx_pkg::neg16(sa) : sa;
				mb = cnt_r[0] ? dimx_pkg::neg16(sb) : sb;
			end
			dimx_pkg::MIX_PFS4: begin
				case (cnt_r)
					2'h0: begin ma = sa;                  mb = sb;                  end
					2'h1: begin ma = dimx_pkg::neg16(sb); mb = sa;                  end
					2'h2: begin ma = dimx_pkg::neg16(sa); mb = dimx_pkg::neg16(sb); end
					default: begin ma = sb;               mb = dimx_pkg::neg16(sa); end
				endcase
			end
			dimx_pkg::MIX_MFS4: begin
				case (cnt_r)
					2'h0: begin ma = sa;                  mb = sb;                  end
					2'h1: begin ma = sb;                  mb = dimx_pkg::neg16(sa); end
					2'h2: begin ma = dimx_pkg::neg16(sa); mb = dimx_pkg::neg16(sb); end
					default: begin ma = dimx_pkg::neg16(sb); mb = sa;               end
				endcase
			end
			default: begin
				ma = sa;
				mb = sb;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst)
			cnt_r <= 2'h0;
		else if (mode_eff == dimx_pkg::MIX_NONE)
			cnt_r <= 2'h0;
		else if (mix_vld_nxt)
			cnt_r <= cnt_r + 2'h1;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			mix_a_r   <= 16'sh0000;
			mix_b_r   <= 16'sh0000;
			mix_vld_r <= 1'b0;
		end else begin
			mix_vld_r <= mix_vld_nxt;
			if (mix_vld_nxt) begin
				mix_a_r <= ma;
				mix_b_r <= mb;
			end
		end
	end

	// ==========================================================
	// offset holding and active registers
	logic [7:0] hold_r [4];

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			for (int n = 0; n < 4; n++) begin
				hold_r[n] <= dimx_pkg::HOLD_RST;
			end
		end else if (i_offset_wr) begin
			hold_r[i_offset_idx] <= i_offset_data;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_offset_a <= dimx_pkg::OFS_RST;
			o_offset_b <= dimx_pkg::OFS_RST;
		end else if (i_offset_wr && i_offset_idx == dimx_pkg::OFS_IDX_TRIG) begin
			o_offset_a <= {hold_r[dimx_pkg::OFS_IDX_A_HI][4:0], i_offset_data};
			o_offset_b <= {hold_r[dimx_pkg::OFS_IDX_LAST][4:0],
			               hold_r[dimx_pkg::OFS_IDX_B_LO]};
		end
	end

	// ==========================================================
	// offset adder and output register
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_dac       <= dimx_pkg::PAIR_RST;
			o_dac_valid <= 1'b0;
		end else begin
			o_dac_valid <= mix_vld_r;
			if (mix_vld_r) begin
				o_dac.a <= dimx_pkg::sat16(40'(mix_a_r) + 40'(o_offset_a));
				o_dac.b <= dimx_pkg::sat16(40'(mix_b_r) + 40'(o_offset_b));
			end
		end
	end

	// ==========================================================
	// checks
	a_mode_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		!i_hb_en |-> mode_eff == dimx_pkg::MIX_NONE)
		else $error("mixing active with interpolator off");

	a_droop_gate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		droop_on |-> i_hb_en)
		else $error("droop filter on without interpolator");

	a_interp_rate: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		i_hb_en [*3] |=> o_dac_valid)
		else $error("interpolated output missing a sample");

	a_cnt_step: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(mode_eff != dimx_pkg::MIX_NONE && mix_vld_nxt) |=> cnt_r == $past(cnt_r) + 2'h1)
		else $error("mixer phase did not advance");

	a_fs2_indep: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(mode_eff == dimx_pkg::MIX_FS2 && mix_vld_nxt) |=>
		mix_a_r == ($past(cnt_r[0]) ? dimx_pkg::neg16($past(sa)) : $past(sa)))
		else $error("fs/2 output not from own channel");

	a_pfs4_step: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(mode_eff == dimx_pkg::MIX_PFS4 && mix_vld_nxt && cnt_r == 2'h1) |=>
		mix_b_r == $past(sa))
		else $error("+fs/4 second step wrong");

	a_offset_load: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_offset_wr && i_offset_idx == dimx_pkg::OFS_IDX_TRIG) |=>
		o_offset_b == {$past(hold_r[3][4:0]), $past(hold_r[2])}
		&& o_offset_a[7:0] == $past(i_offset_data))
		else $error("offset load not simultaneous");

	a_offset_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		(i_offset_wr && i_offset_idx != dimx_pkg::OFS_IDX_TRIG) |=>
		$stable(o_offset_a) && $stable(o_offset_b))
		else $error("active offset changed without trigger");

	a_offset_add: assert property (@(posedge i_clk_sys) disable iff (i_rst)
		mix_vld_r |=> o_dac.b == dimx_pkg::sat16(40'($past(mix_b_r)) + 40'($past(o_offset_b))))
		else $error("offset not added to channel B");

endmodule

// File: dimx_src_model.sv
`timescale 1ns/1ps
module dimx_src_model (
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	input  wire logic               i_take,
	input  wire logic signed [15:0] i_a,
	input  wire logic signed [15:0] i_b,
	input  wire logic               i_alt,
	output dimx_pkg::dimx_pair_type o_smp
);
	logic phase_r;

	// ==========
	// sign flips once per taken pair
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			phase_r <= 1'b0;
		end else if (i_take) begin
			phase_r <= ~phase_r;
		end
	end

	// caller keeps amplitude backed off while droop is on
	always_comb begin
		o_smp.a = (i_alt && phase_r) ? -i_a : i_a;
		o_smp.b = (i_alt && phase_r) ? -i_b : i_b;
	end
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam logic signed [15:0] OA = -16'sh0FFF;
	localparam logic signed [15:0] OB = 16'sh0FFF;
	localparam logic signed [15:0] VA = 16'sh03E8;
	localparam logic signed [15:0] VB = 16'sh012C;
	logic                    i_clk_sys, i_rst, hb_en, droop_en, ofs_wr, alt, dac_valid, smp_take;
	logic [1:0]              mix_sel, ofs_idx, m, mb;
	logic [7:0]              ofs_data;
	logic signed [15:0]      src_a, src_b;
	logic signed [15:0]      ya[8], yb[8];
	logic signed [12:0]      ofs_a, ofs_b;
	dimx_pkg::dimx_pair_type smp, dac;
	int                      failures, cmp_count, nv, r;
	int                      dm[3] = '{32'sh0AC8, 32'sh0A00, 32'sh0A00};

	dimx_src_model u_src (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_take    (smp_take),
		.i_a       (src_a),
		.i_b       (src_b),
		.i_alt     (alt),
		.o_smp     (smp)
	);

	dimx_path u_dut (
		.i_clk_sys     (i_clk_sys),
		.i_rst         (i_rst),
		.i_smp         (smp),
		.o_dac         (dac),
		.o_dac_valid   (dac_valid),
		.o_smp_take    (smp_take),
		.i_hb_en       (hb_en),
		.i_droop_en    (droop_en),
		.i_mix_sel     (mix_sel),
		.i_offset_wr   (ofs_wr),
		.i_offset_idx  (ofs_idx),
		.i_offset_data (ofs_data),
		.o_offset_a    (ofs_a),
		.o_offset_b    (ofs_b)
	);

	// ==========
	// helpers
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic logic signed [15:0] mix_a(input logic [1:0] md, input int p,
		input logic signed [15:0] a, input logic signed [15:0] b);
		if (md == 2'h0)
			return a;
		if (md == 2'h1)
			return p[0] ? -a : a;
		if (!p[0])
			return p[1] ? -a : a;
		return (md[0] ^ p[1]) ? b : -b;
	endfunction

	function automatic int has(input logic signed [15:0] v);
		foreach (ya[i])
			if (ya[i] === v)
				return 1;
		return 0;
	endfunction

	task automatic hold_ofs(input logic [12:0] a, input logic [12:0] b);
		ofs_wr <= 1'b1;
		ofs_idx <= 2'h1;
		ofs_data <= {3'h0, a[12:8]};
		@(posedge i_clk_sys);
		ofs_idx <= 2'h2;
		ofs_data <= b[7:0];
		@(posedge i_clk_sys);
		ofs_idx <= 2'h3;
		ofs_data <= {3'h0, b[12:8]};
		@(posedge i_clk_sys);
		ofs_wr <= 1'b0;
	endtask

	task automatic trig(input logic [7:0] d);
		ofs_wr <= 1'b1;
		ofs_idx <= 2'h0;
		ofs_data <= d;
		@(posedge i_clk_sys);
		ofs_wr <= 1'b0;
	endtask

	task automatic cfg(input logic h, input logic d, input logic [1:0] md,
		input logic signed [15:0] a, input logic signed [15:0] b, input logic al);
		hb_en <= h;
		droop_en <= d;
		mix_sel <= md;
		src_a <= a;
		src_b <= b;
		alt <= al;
		repeat (100) @(posedge i_clk_sys);
	endtask

	task automatic grab();
		int k;
		int g;
		k = 0;
		g = 0;
		nv = 0;
		repeat (16) begin
			@(negedge i_clk_sys);
			if (dac_valid === 1'b1)
				nv++;
		end
		while (k < 8 && g < 100) begin
			@(negedge i_clk_sys);
			g++;
			if (dac_valid === 1'b1) begin
				ya[k] = dac.a;
				yb[k] = dac.b;
				k++;
			end
		end
		check("grab_count", k, 32'h0000_0008);
		@(posedge i_clk_sys);
	endtask

	// ==========
	// clock, watchdog, tests
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end

	initial begin
		repeat (20000) @(posedge i_clk_sys);
		failures++;
		end_of_test();
	end

	initial begin
		{i_rst, hb_en, droop_en, mix_sel, ofs_wr, ofs_idx, ofs_data, alt} = 17'h1_0000;
		src_a = 16'sh0000;
		src_b = 16'sh0000;
		failures = 0;
		cmp_count = 0;
		repeat (4) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		@(negedge i_clk_sys);
		check("dac_reset", dac, 32'h0000_0000);
		@(posedge i_clk_sys);
		hold_ofs(13'h1001, 13'h0FFF);
		@(negedge i_clk_sys);
		check("offset_a_held", ofs_a, 32'h0000_0000);
		check("offset_b_held", ofs_b, 32'h0000_0000);
		@(posedge i_clk_sys);
		trig(8'h01);
		@(negedge i_clk_sys);
		check("offset_a", ofs_a, OA);
		check("offset_b", ofs_b, OB);
		@(posedge i_clk_sys);
		cfg(1'b0, 1'b1, 2'h1, VA, VB, 1'b0);
		grab();
		check("rate_off", nv, 32'h0000_0008);
		foreach (ya[k]) check("bypass_a", ya[k], VA + OA);
		foreach (yb[k]) check("bypass_b", yb[k], VB + OB);
		cfg(1'b1, 1'b0, 2'h0, VA, VB, 1'b0);
		grab();
		check("rate_on", nv, 32'h0000_0010);
		foreach (ya[k]) check("dc_a", ya[k], VA + OA);
		foreach (yb[k]) check("dc_b", yb[k], VB + OB);
		cfg(1'b0, 1'b0, 2'h0, 16'sh8000, 16'sh7FFF, 1'b0);
		grab();
		check("sat_a", ya[0], 16'sh8000);
		check("sat_b", yb[0], 16'sh7FFF);
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			mb = m ^ {1'b0, m[1]};
			cfg(1'b1, 1'b0, m, VA, VB, 1'b0);
			grab();
			r = 0;
			for (int p = 0; p < 4; p++)
				if (mix_a(m, p, VA, VB) + OA === ya[0] && mix_a(mb, p, VB, VA) + OB === yb[0])
					r = p;
			for (int k = 0; k < 8; k++) begin
				check("mix_a", ya[k], mix_a(m, r + k, VA, VB) + OA);
				check("mix_b", yb[k], mix_a(mb, r + k, VB, VA) + OB);
			end
		end
		for (int i = 0; i < 3; i++) begin
			cfg(i != 2, i != 1, 2'h0, 16'sh0A00, 16'sh0A00, 1'b1);
			grab();
			check("peak_pos", has(16'(dm[i]) + OA), 32'h0000_0001);
			check("peak_neg", has(-16'(dm[i]) + OA), 32'h0000_0001);
		end
		end_of_test();
	end
endmodule
